// [rtl/tacc_pkg.sv]
package tacc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned CONV_FAST_HZ = 4_000_000;
  localparam int unsigned CONV_MID_HZ = 2_000_000;
  localparam int unsigned CONV_SLOW_HZ = 1_000_000;
  localparam int unsigned DIV_FAST = SYS_CLK_HZ / CONV_FAST_HZ;
  localparam int unsigned DIV_MID = SYS_CLK_HZ / CONV_MID_HZ;
  localparam int unsigned DIV_SLOW = SYS_CLK_HZ / CONV_SLOW_HZ;
  localparam int unsigned LONG_SAMPLE_NS = 500;
  localparam int unsigned LONG_SAMPLE_CYC = (LONG_SAMPLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SETTLE_STEP_NS = 1000;
  localparam int unsigned SETTLE_STEP_CYC = (SETTLE_STEP_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PRECH_STEP_NS = 100;
  localparam int unsigned PRECH_STEP_CYC = (PRECH_STEP_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SENSE_STEP_NS = 100;
  localparam int unsigned SENSE_STEP_CYC = (SENSE_STEP_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BATCH_UNIT_MS = 1;
  localparam int unsigned BATCH_MS_CYC = BATCH_UNIT_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned BATCH_MAX_MS = 100;
  localparam int unsigned SAMPLE_CONV_CLKS = 3;
  localparam int unsigned RES_HI_BITS = 12;
  localparam int unsigned RES_LO_BITS = 10;

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [1:0] CLK_SEL_FAST = 2'h0;
  localparam logic [1:0] CLK_SEL_MID = 2'h1;
  localparam logic [1:0] CLK_SEL_SLOW = 2'h2;
  localparam logic [1:0] ZONE_OFF = 2'h0;
  localparam logic [1:0] ZONE_INSIDE = 2'h1;
  localparam logic [1:0] ZONE_OUTSIDE = 2'h2;
  localparam logic [1:0] CHAN_AUX = 2'h0;
  localparam logic [1:0] CHAN_TEMPERATURE_MEAS_ONE = 2'h1;
  localparam logic [1:0] CHAN_TEMPERATURE_MEAS_TWO = 2'h2;
  localparam logic [1:0] THR_AUX_HI = 2'h0;
  localparam logic [1:0] THR_AUX_LO = 2'h1;
  localparam logic [1:0] THR_TEMP_HI = 2'h2;
  localparam logic [1:0] THR_TEMP_LO = 2'h3;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned CMD_RES_BIT = 2;
  localparam int unsigned RES_FIELD_BIT = 13;
  localparam logic [15:0] CFG0_RESET = 16'h2800;
  localparam logic [15:0] CFG1_RESET = 16'h0000;
  localparam logic [15:0] CFG2_RESET = 16'h0000;
  localparam logic [11:0] THR_HI_RESET = 12'hFFF;
  localparam logic [11:0] THR_LO_RESET = 12'h000;

  // ****************************************************************
  // Register layouts
  // ****************************************************************
  typedef struct packed {
    logic host_mode;       // 15: 1 = host starts acquisition
    logic stop;            // 14: 1 = converter halted
    logic res_12;          // 13: 1 = 12-bit results
    logic [1:0] clk_sel;   // 12:11
    logic [2:0] settle;    // 10:8
    logic [2:0] precharge; // 7:5
    logic [2:0] sense;     // 4:2
    logic pen_wait;        // 1: pen detect while waiting
    logic long_sample;     // 0
  } tacc_cfg0_type;

  typedef struct packed {
    logic [8:0] unused;
    logic [6:0] delay_ms;
  } tacc_cfg1_type;

  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] aux_zone;
    logic [1:0] temp_zone;
    logic [2:0] mw;
    logic [4:0] filt_en;   // 4 temp, 3 aux, 2 z, 1 y, 0 x
  } tacc_cfg2_type;

  typedef struct packed {
    logic [1:0] chan;
    logic [11:0] value;
  } tacc_result_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRECH = 3'b001,
    ST_SENSE = 3'b010,
    ST_SETTLE = 3'b011,
    ST_SAMPLE = 3'b100,
    ST_CONVERT = 3'b101,
    ST_BATCH = 3'b110
  } tacc_state_type;

endpackage

// [rtl/tacc_top.sv]
`timescale 1ns/1ps
// Behaviour
// - Start by host command or touch; touch default
// - Command bit 1 halts or runs converter
// - 10 or 12-bit result, 12 by default
// - Conversion clock 4, 2 or 1 MHz; 2 default
// - Fastest clock forces 10-bit conversions
// - Wait settling interval before sampling panel
// - Precharge interval then sense interval detects touch
// - Host mode pen-wait: output high when untouched
// - Extended sampling adds 500 ns, off at reset
// - Device mode: 0 to 100 ms between samples
// - Five independent averaging filter enables
// - Zone check on aux and both temperatures
// - Separate zone modes for temperature and aux
// - Four threshold registers hold zone limits
// - Resolution lives at bit 13 of config
module tacc_top #(
  parameter int unsigned BATCH_MS_CYCLES = tacc_pkg::BATCH_MS_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Host configuration writes
  input wire logic [15:0] cfg0_data_i,
  input wire logic cfg0_wr_i,
  input wire logic [15:0] cfg1_data_i,
  input wire logic cfg1_wr_i,
  input wire logic [15:0] cfg2_data_i,
  input wire logic cfg2_wr_i,
  input wire logic [11:0] thr_data_i,
  input wire logic [1:0] thr_sel_i,
  input wire logic thr_wr_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_wr_i,
  // Panel and converter
  input wire logic pen_touch_i,
  input wire tacc_pkg::tacc_result_type result_i,
  input wire logic result_valid_i,
  // Outputs
  output logic drv_en_o,
  output logic precharge_o,
  output logic sense_o,
  output logic sample_o,
  output logic conv_tick_o,
  output logic res_12_o,
  output logic conv_done_o,
  output logic pen_data_avail_out_o,
  output logic busy_o,
  output logic [4:0] filt_en_o,
  output logic [2:0] filt_mw_o,
  output logic aux_zone_o,
  output logic temp_zone_o
);

  // Elaboration guard: the interval counter holds at most 24 bits
  if (BATCH_MS_CYCLES < 1 || BATCH_MS_CYCLES > 16_777_215) begin
    $error("BATCH_MS_CYCLES out of range");
  end

  // ****************************************************************
  // Configuration store
  // ****************************************************************
  tacc_pkg::tacc_cfg0_type converter_config_reg, act_reg;
  tacc_pkg::tacc_cfg1_type batch_delay_config_reg;
  tacc_pkg::tacc_cfg2_type filter_zone_config_reg;
  logic [11:0] thr_reg [4];
  logic start_req_reg;
  tacc_pkg::tacc_state_type state_reg, state_next;
  logic [23:0] cnt_reg;
  logic [7:0] div_reg;
  logic [6:0] ms_reg;
  logic conv_tick;
  logic [7:0] div_max;
  logic res_eff;
  logic pen_seen_reg;

  // Converter config; direct command byte shares stop and resolution
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      converter_config_reg <= tacc_pkg::CFG0_RESET;
    end else if (cfg0_wr_i) begin
      converter_config_reg <= cfg0_data_i;
    end else if (cmd_wr_i) begin
      converter_config_reg.stop <= cmd_byte_i[tacc_pkg::CMD_STOP_BIT];
      converter_config_reg.res_12 <= cmd_byte_i[tacc_pkg::CMD_RES_BIT];
    end
  end

  // Other configuration words and thresholds
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      batch_delay_config_reg <= tacc_pkg::CFG1_RESET;
      filter_zone_config_reg <= tacc_pkg::CFG2_RESET;
      thr_reg[tacc_pkg::THR_AUX_HI] <= tacc_pkg::THR_HI_RESET;
      thr_reg[tacc_pkg::THR_AUX_LO] <= tacc_pkg::THR_LO_RESET;
      thr_reg[tacc_pkg::THR_TEMP_HI] <= tacc_pkg::THR_HI_RESET;
      thr_reg[tacc_pkg::THR_TEMP_LO] <= tacc_pkg::THR_LO_RESET;
    end else begin
      if (cfg1_wr_i) begin
        batch_delay_config_reg <= cfg1_data_i;
      end
      if (cfg2_wr_i) begin
        filter_zone_config_reg <= cfg2_data_i;
      end
      if (thr_wr_i) begin
        thr_reg[thr_sel_i] <= thr_data_i;
      end
    end
  end

  // Pending host start; a new command during a sequence is kept, not lost
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_req_reg <= 1'b0;
    end else if (cmd_wr_i && cmd_byte_i[tacc_pkg::CMD_START_BIT]) begin
      start_req_reg <= 1'b1;
    end else if (state_reg == tacc_pkg::ST_IDLE && state_next == tacc_pkg::ST_SETTLE) begin
      // Cleared only when really taken, so a halted converter keeps the request
      start_req_reg <= 1'b0;
    end
  end

  // Active copy taken only while idle, so a running conversion is untouched
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_reg <= tacc_pkg::CFG0_RESET;
    end else if (state_reg == tacc_pkg::ST_IDLE) begin
      act_reg <= converter_config_reg;
    end
  end

  // ****************************************************************
  // Conversion clock enable
  // ****************************************************************
  always_comb begin
    case (act_reg.clk_sel)
      tacc_pkg::CLK_SEL_FAST: div_max = 8'(tacc_pkg::DIV_FAST - 1);
      tacc_pkg::CLK_SEL_SLOW: div_max = 8'(tacc_pkg::DIV_SLOW - 1);
      default: div_max = 8'(tacc_pkg::DIV_MID - 1);
    endcase
  end

  // Fastest clock cannot resolve 12 bits, so it is capped at 10
  assign res_eff = act_reg.res_12 && (act_reg.clk_sel != tacc_pkg::CLK_SEL_FAST);
  assign conv_tick = (div_reg == div_max);

  // Free-running divider giving a one-cycle tick per conversion clock
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 8'h00;
    end else if (conv_tick || div_reg > div_max) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic cnt_done;
  logic [6:0] batch_ms;
  assign cnt_done = (cnt_reg == 24'h000000);
  assign batch_ms = (batch_delay_config_reg.delay_ms > 7'(tacc_pkg::BATCH_MAX_MS)) ?
                    7'(tacc_pkg::BATCH_MAX_MS) : batch_delay_config_reg.delay_ms;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tacc_pkg::ST_IDLE: begin
        if (!converter_config_reg.stop) begin
          if (!converter_config_reg.host_mode || converter_config_reg.pen_wait) begin
            state_next = tacc_pkg::ST_PRECH;
          end
          if (converter_config_reg.host_mode && start_req_reg) begin
            state_next = tacc_pkg::ST_SETTLE;
          end
        end
      end
      tacc_pkg::ST_PRECH: if (cnt_done) state_next = tacc_pkg::ST_SENSE;
      tacc_pkg::ST_SENSE: begin
        if (cnt_done) begin
          state_next = (pen_touch_i && !act_reg.host_mode) ? tacc_pkg::ST_SETTLE : tacc_pkg::ST_IDLE;
        end
      end
      tacc_pkg::ST_SETTLE: if (cnt_done) state_next = tacc_pkg::ST_SAMPLE;
      tacc_pkg::ST_SAMPLE: if (cnt_done) state_next = tacc_pkg::ST_CONVERT;
      tacc_pkg::ST_CONVERT: begin
        if (cnt_done) begin
          state_next = act_reg.host_mode ? tacc_pkg::ST_IDLE : tacc_pkg::ST_BATCH;
        end
      end
      tacc_pkg::ST_BATCH: if (cnt_done && ms_reg == 7'h00) state_next = tacc_pkg::ST_IDLE;
      default: state_next = tacc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= tacc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Interval counter; loaded on entry using the configuration about to apply
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 24'h000000;
      ms_reg <= 7'h00;
    end else if (state_next != state_reg) begin
      case (state_next)
        tacc_pkg::ST_PRECH: cnt_reg <= 24'(converter_config_reg.precharge * tacc_pkg::PRECH_STEP_CYC);
        tacc_pkg::ST_SENSE: cnt_reg <= 24'(act_reg.sense * tacc_pkg::SENSE_STEP_CYC);
        tacc_pkg::ST_SETTLE: begin
          // From idle the copy is not taken yet; after a sense the running copy rules
          if (state_reg == tacc_pkg::ST_IDLE) begin
            cnt_reg <= 24'(converter_config_reg.settle * tacc_pkg::SETTLE_STEP_CYC);
          end else begin
            cnt_reg <= 24'(act_reg.settle * tacc_pkg::SETTLE_STEP_CYC);
          end
        end
        tacc_pkg::ST_SAMPLE: begin
          cnt_reg <= act_reg.long_sample ? 24'(tacc_pkg::LONG_SAMPLE_CYC) : 24'h000000;
        end
        tacc_pkg::ST_CONVERT: cnt_reg <= 24'(tacc_pkg::SAMPLE_CONV_CLKS) +
                                         (res_eff ? 24'(tacc_pkg::RES_HI_BITS) : 24'(tacc_pkg::RES_LO_BITS));
        tacc_pkg::ST_BATCH: begin
          cnt_reg <= 24'(BATCH_MS_CYCLES - 1);
          ms_reg <= batch_ms;
        end
        default: cnt_reg <= 24'h000000;
      endcase
    end else if (state_reg == tacc_pkg::ST_BATCH) begin
      if (ms_reg == 7'h00) begin
        cnt_reg <= 24'h000000;
      end else if (cnt_done) begin
        cnt_reg <= 24'(BATCH_MS_CYCLES - 1);
        ms_reg <= ms_reg - 7'h01;
      end else begin
        cnt_reg <= cnt_reg - 24'h000001;
      end
    end else if (state_reg == tacc_pkg::ST_CONVERT) begin
      if (conv_tick && !cnt_done) begin
        cnt_reg <= cnt_reg - 24'h000001;
      end
    end else if (!cnt_done) begin
      cnt_reg <= cnt_reg - 24'h000001;
    end
  end

  // ****************************************************************
  // Pen status
  // ****************************************************************
  // Background sense result in host mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pen_seen_reg <= 1'b0;
    end else if (state_reg == tacc_pkg::ST_SENSE && cnt_done) begin
      pen_seen_reg <= pen_touch_i;
    end
  end

  // Registered outputs of the sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_en_o <= 1'b0;
      precharge_o <= 1'b0;
      sense_o <= 1'b0;
      sample_o <= 1'b0;
      conv_tick_o <= 1'b0;
      res_12_o <= 1'b1;
      conv_done_o <= 1'b0;
      busy_o <= 1'b0;
      pen_data_avail_out_o <= 1'b1;
    end else begin
      drv_en_o <= state_reg == tacc_pkg::ST_SETTLE || state_reg == tacc_pkg::ST_SAMPLE;
      precharge_o <= state_reg == tacc_pkg::ST_PRECH;
      sense_o <= state_reg == tacc_pkg::ST_SENSE;
      sample_o <= state_reg == tacc_pkg::ST_SAMPLE;
      conv_tick_o <= conv_tick && state_reg == tacc_pkg::ST_CONVERT;
      res_12_o <= res_eff;
      conv_done_o <= state_reg == tacc_pkg::ST_CONVERT && cnt_done;
      busy_o <= state_reg != tacc_pkg::ST_IDLE;
      // Host mode with pen wait: high means nobody touches the panel
      if (act_reg.host_mode && act_reg.pen_wait) begin
        pen_data_avail_out_o <= !pen_seen_reg;
      end else begin
        pen_data_avail_out_o <= !(state_reg == tacc_pkg::ST_CONVERT && cnt_done);
      end
    end
  end

  // ****************************************************************
  // Filter enables and zone detection
  // ****************************************************************
  logic in_aux, in_temp;
  assign in_aux = result_i.value <= thr_reg[tacc_pkg::THR_AUX_HI] && result_i.value >= thr_reg[tacc_pkg::THR_AUX_LO];
  assign in_temp = result_i.value <= thr_reg[tacc_pkg::THR_TEMP_HI] &&
                   result_i.value >= thr_reg[tacc_pkg::THR_TEMP_LO];

  // Flags follow the latest result of their channel; reserved mode acts as off
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_en_o <= 5'h00;
      filt_mw_o <= 3'h0;
      aux_zone_o <= 1'b0;
      temp_zone_o <= 1'b0;
    end else begin
      filt_en_o <= filter_zone_config_reg.filt_en;
      filt_mw_o <= filter_zone_config_reg.mw;
      if (result_valid_i && result_i.chan == tacc_pkg::CHAN_AUX) begin
        case (filter_zone_config_reg.aux_zone)
          tacc_pkg::ZONE_INSIDE: aux_zone_o <= in_aux;
          tacc_pkg::ZONE_OUTSIDE: aux_zone_o <= !in_aux;
          default: aux_zone_o <= 1'b0;
        endcase
      end
      if (result_valid_i && (result_i.chan == tacc_pkg::CHAN_TEMPERATURE_MEAS_ONE || result_i.chan == tacc_pkg::CHAN_TEMPERATURE_MEAS_TWO)) begin
        case (filter_zone_config_reg.temp_zone)
          tacc_pkg::ZONE_INSIDE: temp_zone_o <= in_temp;
          tacc_pkg::ZONE_OUTSIDE: temp_zone_o <= !in_temp;
          default: temp_zone_o <= 1'b0;
        endcase
      end
    end
  end

endmodule

// [sim/tacc_top_sva.sv]
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the sequencer
// ****************************************************************
module tacc_top_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Host writes
  input wire logic [15:0] cfg0_data_i,
  input wire logic cfg0_wr_i,
  input wire logic [15:0] cfg2_data_i,
  input wire logic cfg2_wr_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_wr_i,
  // Sequencer outputs
  input wire logic drv_en_o,
  input wire logic precharge_o,
  input wire logic sense_o,
  input wire logic sample_o,
  input wire logic conv_tick_o,
  input wire logic conv_done_o,
  input wire logic busy_o,
  input wire logic [4:0] filt_en_o,
  input wire logic [2:0] filt_mw_o
);
  logic stop_reg;
  logic [15:0] cfg2_reg;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Shadow of the halt bit; a config write beats a command in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_reg <= 1'b0;
    end else if (cfg0_wr_i) begin
      stop_reg <= cfg0_data_i[14];
    end else if (cmd_wr_i) begin
      stop_reg <= cmd_byte_i[tacc_pkg::CMD_STOP_BIT];
    end
  end

  // Last filter word, held so the copy can be checked two cycles on
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg2_reg <= tacc_pkg::CFG2_RESET;
    end else if (cfg2_wr_i) begin
      cfg2_reg <= cfg2_data_i;
    end
  end

  a_done_single_pulse: assert property (conv_done_o |=> !conv_done_o [*8])
    else $error("conversion done repeated within eight cycles");
  a_tick_min_spacing: assert property (conv_tick_o |=> !conv_tick_o [*8])
    else $error("conversion ticks closer than the fastest divider");
  a_tick_in_convert: assert property (conv_tick_o |-> !sample_o && !precharge_o && !sense_o)
    else $error("conversion tick outside the convert phase");
  a_sample_driven: assert property (sample_o |-> drv_en_o)
    else $error("sampling while panel drivers are off");
  a_phase_exclusive: assert property (!(precharge_o && sense_o) && !(sense_o && drv_en_o))
    else $error("touch detect phases overlap");
  a_idle_quiet: assert property (!busy_o && !$past(busy_o) |-> !drv_en_o && !conv_tick_o && !precharge_o)
    else $error("phase output active while idle");
  a_stop_holds_idle: assert property (stop_reg && $past(stop_reg) && $past(stop_reg, 2) && !busy_o |=> !busy_o)
    else $error("halted converter left idle");
  a_filter_copy: assert property (cfg2_wr_i |=> ##1 (filt_en_o == cfg2_reg[4:0] && filt_mw_o == cfg2_reg[7:5]))
    else $error("filter enables do not follow the written word");
endmodule

bind tacc_top tacc_top_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg0_data_i(cfg0_data_i),
  .cfg0_wr_i(cfg0_wr_i), .cfg2_data_i(cfg2_data_i), .cfg2_wr_i(cfg2_wr_i), .cmd_byte_i(cmd_byte_i),
  .cmd_wr_i(cmd_wr_i), .drv_en_o(drv_en_o), .precharge_o(precharge_o), .sense_o(sense_o),
  .sample_o(sample_o), .conv_tick_o(conv_tick_o), .conv_done_o(conv_done_o), .busy_o(busy_o),
  .filt_en_o(filt_en_o), .filt_mw_o(filt_mw_o));

// [sim/tacc_host_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Host processor: configuration and command writes
// ****************************************************************
module tacc_host_model #(
  parameter logic [2:0] MW_RESERVED = 3'h7
) (
  // Clock
  input wire logic mclk_i,
  // Shared write data, threshold select, one strobe per target
  output logic [15:0] data_o,
  output logic [1:0] sel_o,
  output logic [4:0] wr_o
);
  // Strobes idle low; data starts on a pattern rather than zero
  initial begin
    data_o = 16'hA5A5;
    sel_o = 2'h0;
    wr_o = 5'h00;
  end

  // Kind 0 cfg0, 1 cfg1, 2 cfg2, 3 threshold, 4 command; data inverted once released
  task automatic put(input int kind, input logic [15:0] d, input logic [1:0] sel);
    if (kind == 2 && d[7:5] == MW_RESERVED) begin
      d[7:5] = 3'h0;
    end
    @(posedge mclk_i);
    #1;
    data_o = d;
    sel_o = sel;
    wr_o = 5'(1 << kind);
    @(posedge mclk_i);
    #1;
    wr_o = 5'h00;
    data_o = ~d;
    sel_o = ~sel;
  endtask
endmodule

// [sim/tacc_top_tb.sv]
`timescale 1ns/1ps
module tacc_top_tb;
  // ****************************************************************
  // Signals, instances and checking
  // ****************************************************************
  typedef struct {int ticks; int per; int drv; logic res;} tacc_exp_type;
  localparam int BATCH_CYC = 20;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pen_touch = 1'b0;
  logic result_valid = 1'b0;
  tacc_pkg::tacc_result_type result = '0;
  logic [15:0] h_data;
  logic [1:0] h_sel;
  logic [4:0] h_wr;
  logic drv_en, precharge, sense, sample, conv_tick, res_12, conv_done, pen_avail, busy, aux_zone, temp_zone;
  logic [4:0] filt_en;
  logic [2:0] filt_mw;
  logic [15:0] rnd = 16'h000B;
  tacc_exp_type exp_q[$];
  tacc_exp_type got_e;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_tick = 0;
  int last_tick = 0;
  int per = 0;
  int n_drv = 0;

  tacc_host_model u_host (.mclk_i(mclk_i), .data_o(h_data), .sel_o(h_sel), .wr_o(h_wr));
  tacc_top #(.BATCH_MS_CYCLES(BATCH_CYC)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cfg0_data_i(h_data), .cfg0_wr_i(h_wr[0]), .cfg1_data_i(h_data), .cfg1_wr_i(h_wr[1]),
    .cfg2_data_i(h_data), .cfg2_wr_i(h_wr[2]), .thr_data_i(h_data[11:0]), .thr_sel_i(h_sel),
    .thr_wr_i(h_wr[3]), .cmd_byte_i(h_data[7:0]), .cmd_wr_i(h_wr[4]), .pen_touch_i(pen_touch),
    .result_i(result), .result_valid_i(result_valid), .drv_en_o(drv_en), .precharge_o(precharge),
    .sense_o(sense), .sample_o(sample), .conv_tick_o(conv_tick), .res_12_o(res_12), .conv_done_o(conv_done),
    .pen_data_avail_out_o(pen_avail), .busy_o(busy), .filt_en_o(filt_en), .filt_mw_o(filt_mw),
    .aux_zone_o(aux_zone), .temp_zone_o(temp_zone));

  // Free-running 200 MHz clock
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Host-mode word: settle code 1, long sampling on odd clock codes
  function automatic logic [15:0] cfg0v(input int i);
    logic [1:0] c;
    c = (i < 4) ? 2'(i) : 2'h1;
    return {1'b1, 1'b0, i < 4, c, 3'h1, 6'h00, 1'b0, c[0]};
  endfunction

  function automatic logic ph(input int s);
    return (s == 0) ? precharge : (s == 1) ? sense : conv_done;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // Waits for a phase to start, then counts its length in cycles
  task automatic plen(input int s, output int n);
    n = 0;
    while (ph(s) !== 1'b1) tick(1);
    while (ph(s) === 1'b1) begin
      tick(1);
      n++;
    end
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watcher: counts ticks and driver cycles, checks each conversion against the oldest note while notes are queued
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
    if (!busy) begin
      n_tick = 0;
      n_drv = 0;
    end
    if (conv_tick) begin
      n_tick++;
      per = cyc - last_tick;
      last_tick = cyc;
    end
    if (drv_en) n_drv++;
    if (conv_done === 1'b1 && exp_q.size() > 0) begin
      got_e = exp_q.pop_front();
      cmp(16'(pen_avail), 16'h0000);
      cmp(16'(res_12), 16'(got_e.res));
      cmp(16'(n_tick), 16'(got_e.ticks));
      cmp(16'(per), 16'(got_e.per));
      cmp_rng(n_drv, got_e.drv, got_e.drv + 4);
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int n;
    static int dl[3] = '{100, 127, 0};
    tacc_exp_type e;
    logic [15:0] w;
    logic [11:0] v, lo, hi;
    logic [1:0] c, ch, md;
    logic inr, z;
    repeat (4) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    tick(1);
    cmp(16'(res_12), 16'h0001);
    cmp(16'(pen_avail), 16'h0001);
    // A touch alone starts a 12-bit run at the default clock
    exp_q.push_back('{15, tacc_pkg::DIV_MID, 0, 1'b1});
    pen_touch = 1'b1;
    plen(2, n);
    pen_touch = 0;
    u_host.put(4, 16'h0006, 2'h0);
    tick(2000);
    cmp(16'(busy), 16'h0000);
    // Host starts; the next word lands mid-run and must wait for the next sequence
    u_host.put(0, cfg0v(0), 2'h0);
    for (int i = 0; i < 5; i++) begin
      w = cfg0v(i);
      c = w[12:11];
      e.res = w[13] && (c != tacc_pkg::CLK_SEL_FAST);
      e.ticks = tacc_pkg::SAMPLE_CONV_CLKS + (e.res ? tacc_pkg::RES_HI_BITS : tacc_pkg::RES_LO_BITS);
      e.per = (c == tacc_pkg::CLK_SEL_FAST) ? tacc_pkg::DIV_FAST : (c == tacc_pkg::CLK_SEL_SLOW) ?
        tacc_pkg::DIV_SLOW : tacc_pkg::DIV_MID;
      e.drv = tacc_pkg::SETTLE_STEP_CYC + (c[0] ? tacc_pkg::LONG_SAMPLE_CYC : 0);
      exp_q.push_back(e);
      u_host.put(4, {13'h0000, w[13], 2'h1}, 2'h0);
      tick(250);
      if (i < 4) u_host.put(0, cfg0v(i + 1), 2'h0);
      plen(2, n);
      tick(20);
    end
    // Touch mode: precharge 2, sense 3, then the batch gap before the next sequence
    pen_touch = 1'b1;
    foreach (dl[k]) begin
      u_host.put(1, 16'(dl[k]), 2'h0);
      u_host.put(0, 16'h284C, 2'h0);
      plen(2, n);
      plen(0, n);
      cmp_rng(n, 2 * tacc_pkg::PRECH_STEP_CYC, 2 * tacc_pkg::PRECH_STEP_CYC + 2);
      plen(1, n);
      cmp_rng(n, 3 * tacc_pkg::SENSE_STEP_CYC, 3 * tacc_pkg::SENSE_STEP_CYC + 2);
      plen(2, n);
      n = 0;
      while (precharge !== 1'b1) begin
        tick(1);
        n++;
      end
      cmp_rng(n, ((dl[k] > 100) ? 100 : dl[k]) * BATCH_CYC, ((dl[k] > 100) ? 100 : dl[k]) * BATCH_CYC + 8);
    end
    // Host mode with background pen detect
    pen_touch = 1'b0;
    u_host.put(0, 16'hA826, 2'h0);
    tick(2500);
    cmp(16'(pen_avail), 16'h0001);
    pen_touch = 1'b1;
    tick(300);
    cmp(16'(pen_avail), 16'h0000);
    // Zone limits, then each mode on aux and temperature (temp mode is 3 minus aux) with boundary and random results
    u_host.put(3, 16'h0C00, tacc_pkg::THR_AUX_HI);
    u_host.put(3, 16'h0400, tacc_pkg::THR_AUX_LO);
    u_host.put(3, 16'h0900, tacc_pkg::THR_TEMP_HI);
    u_host.put(3, 16'h0300, tacc_pkg::THR_TEMP_LO);
    for (int m = 0; m < 4; m++) begin
      rnd = nxt(rnd);
      w = {4'h0, 2'(m), 2'(3 - m), rnd[7:0]};
      if (w[7:5] == u_host.MW_RESERVED) w[7:5] = 3'h0;
      u_host.put(2, w, 2'h0);
      tick(3);
      cmp(16'({filt_mw, filt_en}), 16'(w[7:0]));
      for (int k = 0; k < 6; k++) begin
        rnd = nxt(rnd);
        ch = 2'(k % 3);
        lo = (ch == tacc_pkg::CHAN_AUX) ? 12'h400 : 12'h300;
        hi = (ch == tacc_pkg::CHAN_AUX) ? 12'hC00 : 12'h900;
        v = (k == 0) ? lo : (k == 1) ? hi : (k == 2) ? hi + 12'h001 : rnd[11:0];
        md = (ch == tacc_pkg::CHAN_AUX) ? 2'(m) : 2'(3 - m);
        inr = (v >= lo) && (v <= hi);
        z = (md == tacc_pkg::ZONE_INSIDE) ? inr : (md == tacc_pkg::ZONE_OUTSIDE) ? !inr : 1'b0;
        result = '{chan: ch, value: v};
        result_valid = 1'b1;
        tick(1);
        result_valid = 1'b0;
        result.value = ~v;
        tick(2);
        cmp(16'((ch == tacc_pkg::CHAN_AUX) ? aux_zone : temp_zone), 16'(z));
      end
    end
    conclude();
  end
endmodule
